// ### rtl/rspc_clk_div.sv
/*
  Internal bus clock derivation from the sampled host bus clock input.
  Assumes the host bus clock is slower than clk and synchronous to it.
*/
module rspc_clk_div
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic halve,
  // Host bus clock sample and derived clock
  input  wire logic host_bus_clock_in,
  output logic      bus_clk_out
);

  logic prev_r;
  logic prev_nxt;
  logic out_r;
  logic out_nxt;

  // ****************************************************************
  // Divider
  // ****************************************************************
  always_comb
  begin
    prev_nxt = host_bus_clock_in;
    if (halve)
    begin
      // Toggle once per rising edge: half the input rate
      out_nxt = (host_bus_clock_in && !prev_r) ? !out_r : out_r;
    end
    else
    begin
      out_nxt = host_bus_clock_in;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prev_r <= 1'b0;
      out_r  <= 1'b0;
    end
    else
    begin
      prev_r <= prev_nxt;
      out_r  <= out_nxt;
    end
  end

  assign bus_clk_out = out_r;

endmodule : rspc_clk_div

// ### rtl/rspc_pkg.sv
/*
  Constants for the reset strap and pin configuration block: register
  offsets, field positions, reset values and the strap encodings.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package rspc_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 32;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [3:0] OFS_STRAP_STATUS = 4'h0;
  localparam logic [3:0] OFS_PIN_CTRL     = 4'h4;
  localparam logic [3:0] OFS_PIN_STATUS   = 4'h8;

  // ****************************************************************
  // Strap status fields
  // ****************************************************************
  localparam int unsigned STS_CLK_DIV_BIT  = 0;
  localparam int unsigned STS_EXP_PORT_BIT = 1;
  localparam int unsigned STS_PWR_DN_BIT   = 2;
  localparam int unsigned STS_WAIT_DRV_BIT = 3;
  localparam int unsigned STS_MEM_CFG_LSB  = 4;
  localparam int unsigned STS_LOCKED_BIT   = 6;

  // ****************************************************************
  // Pin control fields and reset values
  // ****************************************************************
  localparam int unsigned CTL_GP2_OUT_BIT  = 0;
  localparam int unsigned CTL_GP2_DIR_BIT  = 1;
  localparam logic        GP2_OUT_RST      = 1'b0;
  localparam logic        GP2_DIR_RST      = 1'b0;

  // ****************************************************************
  // Pin status fields
  // ****************************************************************
  localparam int unsigned PST_GP2_IN_BIT   = 0;
  localparam int unsigned PST_BUS_CLK_BIT  = 1;
  localparam int unsigned PST_PD_PANEL_DATA_READY_BIT  = 2;
  localparam int unsigned PST_PD_MEM_ADDR_BIT11_BIT  = 3;

  // ****************************************************************
  // Strap encodings
  // ****************************************************************
  localparam logic       CLK_DIV_HALVE     = 1'b0;
  localparam logic       EXP_PORT_ON       = 1'b1;
  localparam logic       PWR_DN_ENABLED    = 1'b0;
  localparam logic       WAIT_TRI_IDLE     = 1'b1;
  localparam logic [1:0] MEM_CFG_FULL_ADDR = 2'h3;
  localparam logic [3:0] STRAP_RST         = 4'h0;
  localparam logic [1:0] MEM_CFG_RST       = 2'h0;

endpackage : rspc_pkg

// ### rtl/rspc_top.sv
/*
  Reset strap latch and shared pin configuration: latches four
  configuration straps plus the memory layout straps after reset and
  steers the bus clock, upper panel data, data-ready, address bit 11
  and wait pins from them. Registers sit on an Avalon-MM slave.
  Assumes all inputs are synchronous to clk and straps held in reset.
*/
// Functional notes
// - Clock-divide strap selects halved or undivided host bus clock internally.
// - Expansion strap selects direct 16-bit passive panel drive or expansion port.
// - Power-down strap makes data-ready or address bit 11 the power-down output.
// - Wait-drive strap drives wait always or tristates it when host is idle.
// - Expansion signals reach upper panel data only when its strap latched 1.
// - Enabled expansion port takes upper eight panel data pins; data-ready follows power-down strap only in the full address layout.
module rspc_top
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Strap inputs
  input  wire logic        clock_divide_strap,
  input  wire logic        expansion_port_strap,
  input  wire logic        power_down_pin_strap,
  input  wire logic        wait_drive_strap,
  input  wire logic [1:0]  mem_config_strap,
  // Host bus
  input  wire logic        host_bus_clock_in,
  input  wire logic        host_access,
  input  wire logic        host_wait_req,
  output logic             bus_clk_int,
  output logic             wait_n_out,
  output logic             wait_n_oe_n,
  // Panel side
  input  wire logic [7:0]  panel_pixel_upper,
  input  wire logic        panel_ready_int,
  output logic      [7:0]  panel_data_upper,
  output logic             panel_data_ready,
  // Expansion port side
  input  wire logic [7:0]  expansion_data,
  input  wire logic        expansion_power_down,
  output logic             expansion_active,
  // Memory address bit 11 / general pin two
  input  wire logic        mem_addr_int11,
  input  wire logic        mem_addr_bit11_in,
  output logic             mem_addr_bit11_out,
  output logic             mem_addr_bit11_oe_n
);

  // ****************************************************************
  // Strap latch state machine
  // ****************************************************************
  typedef enum logic [1:0]
  {
    RSPC_ST_WAIT   = 2'b01,
    RSPC_ST_LOCKED = 2'b10
  } rspc_state_e;

  rspc_state_e state_r;
  rspc_state_e state_nxt;
  logic [3:0]  strap_r;
  logic [3:0]  strap_nxt;
  logic [1:0]  mem_cfg_r;
  logic [1:0]  mem_cfg_nxt;

  logic halve_clk;
  logic exp_en;
  logic pd_on_panel_data_ready;
  logic pd_on_mem_addr_bit11;
  logic wait_tri;
  logic full_addr;

  // Capture on the first edge after release, since a synchronous reset
  // must load constants only; the board keeps the straps steady.
  always_comb
  begin
    state_nxt   = state_r;
    strap_nxt   = strap_r;
    mem_cfg_nxt = mem_cfg_r;
    unique case (state_r)
      RSPC_ST_WAIT:
      begin
        strap_nxt   = {wait_drive_strap, power_down_pin_strap,
                       expansion_port_strap, clock_divide_strap};
        mem_cfg_nxt = mem_config_strap;
        state_nxt   = RSPC_ST_LOCKED;
      end
      RSPC_ST_LOCKED:
      begin
        state_nxt = RSPC_ST_LOCKED;
      end
      default:
      begin
        state_nxt = RSPC_ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r   <= RSPC_ST_WAIT;
      strap_r   <= rspc_pkg::STRAP_RST;
      mem_cfg_r <= rspc_pkg::MEM_CFG_RST;
    end
    else
    begin
      state_r   <= state_nxt;
      strap_r   <= strap_nxt;
      mem_cfg_r <= mem_cfg_nxt;
    end
  end

  // ****************************************************************
  // Decoded configuration
  // ****************************************************************
  // Pins stay in their plain panel/general pin two role until the latch is done
  assign halve_clk  = (strap_r[rspc_pkg::STS_CLK_DIV_BIT] == rspc_pkg::CLK_DIV_HALVE);
  assign exp_en     = (state_r == RSPC_ST_LOCKED) &&
                      (strap_r[rspc_pkg::STS_EXP_PORT_BIT] == rspc_pkg::EXP_PORT_ON);
  assign full_addr  = (mem_cfg_r == rspc_pkg::MEM_CFG_FULL_ADDR);
  assign pd_on_panel_data_ready = (state_r == RSPC_ST_LOCKED) && full_addr &&
                      (strap_r[rspc_pkg::STS_PWR_DN_BIT] == rspc_pkg::PWR_DN_ENABLED);
  assign pd_on_mem_addr_bit11 = (state_r == RSPC_ST_LOCKED) && !full_addr &&
                      (strap_r[rspc_pkg::STS_PWR_DN_BIT] == rspc_pkg::PWR_DN_ENABLED);
  assign wait_tri   = (strap_r[rspc_pkg::STS_WAIT_DRV_BIT] == rspc_pkg::WAIT_TRI_IDLE);

  // ****************************************************************
  // Bus clock
  // ****************************************************************
  logic bus_clk_div;

  rspc_clk_div u_clk_div
  (
    .clk               (clk),
    .rst_n             (rst_n),
    .halve             (halve_clk),
    .host_bus_clock_in (host_bus_clock_in),
    .bus_clk_out       (bus_clk_div)
  );

  // ****************************************************************
  // Register file and Avalon-MM slave
  // ****************************************************************
  logic        gp2_out_r;
  logic        gp2_out_nxt;
  logic        gp2_dir_r;
  logic        gp2_dir_nxt;
  logic        waitreq_r;
  logic        waitreq_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        req;

  assign req = avs_read || avs_write;

  // One wait cycle per access: the answer is registered, so every
  // output of the slave comes from a flip-flop.
  always_comb
  begin
    waitreq_nxt = !(req && waitreq_r);
    rdata_nxt   = rdata_r;
    gp2_out_nxt = gp2_out_r;
    gp2_dir_nxt = gp2_dir_r;
    if (avs_read && waitreq_r)
    begin
      rdata_nxt = 32'h0;
      unique case (avs_address)
        rspc_pkg::OFS_STRAP_STATUS:
        begin
          rdata_nxt[3:0] = strap_r;
          rdata_nxt[rspc_pkg::STS_MEM_CFG_LSB +: 2] = mem_cfg_r;
          rdata_nxt[rspc_pkg::STS_LOCKED_BIT] = (state_r == RSPC_ST_LOCKED);
        end
        rspc_pkg::OFS_PIN_CTRL:
        begin
          rdata_nxt[rspc_pkg::CTL_GP2_OUT_BIT] = gp2_out_r;
          rdata_nxt[rspc_pkg::CTL_GP2_DIR_BIT] = gp2_dir_r;
        end
        rspc_pkg::OFS_PIN_STATUS:
        begin
          rdata_nxt[rspc_pkg::PST_GP2_IN_BIT]  = mem_addr_bit11_in;
          rdata_nxt[rspc_pkg::PST_BUS_CLK_BIT] = bus_clk_div;
          rdata_nxt[rspc_pkg::PST_PD_PANEL_DATA_READY_BIT] = pd_on_panel_data_ready;
          rdata_nxt[rspc_pkg::PST_PD_MEM_ADDR_BIT11_BIT] = pd_on_mem_addr_bit11;
        end
        default:
        begin
          rdata_nxt = 32'h0;
        end
      endcase
    end
    // Write lands at the edge where the master sees waitrequest low
    if (avs_write && !waitreq_r && (avs_address == rspc_pkg::OFS_PIN_CTRL))
    begin
      gp2_out_nxt = avs_writedata[rspc_pkg::CTL_GP2_OUT_BIT];
      gp2_dir_nxt = avs_writedata[rspc_pkg::CTL_GP2_DIR_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      waitreq_r <= 1'b1;
      rdata_r   <= 32'h0;
      gp2_out_r <= rspc_pkg::GP2_OUT_RST;
      gp2_dir_r <= rspc_pkg::GP2_DIR_RST;
    end
    else
    begin
      waitreq_r <= waitreq_nxt;
      rdata_r   <= rdata_nxt;
      gp2_out_r <= gp2_out_nxt;
      gp2_dir_r <= gp2_dir_nxt;
    end
  end

  assign avs_waitrequest = waitreq_r;
  assign avs_readdata    = rdata_r;

  // ****************************************************************
  // Pin multiplexing
  // ****************************************************************
  logic [7:0] pdu_r;
  logic [7:0] pdu_nxt;
  logic       panel_data_ready_r;
  logic       panel_data_ready_nxt;
  logic       mem_addr_bit11_out_r;
  logic       mem_addr_bit11_out_nxt;
  logic       mem_addr_bit11_oe_n_r;
  logic       mem_addr_bit11_oe_n_nxt;
  logic       wait_r;
  logic       wait_nxt;
  logic       wait_oe_n_r;
  logic       wait_oe_n_nxt;
  logic       exp_act_r;
  logic       bclk_r;

  // Upper panel data: one selector per pin
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pdu
      always_comb
      begin
        pdu_nxt[gi] = exp_en ? expansion_data[gi]
                             : panel_pixel_upper[gi];
      end
    end
  endgenerate

  always_comb
  begin
    // Data-ready carries power-down only in the full address layout
    panel_data_ready_nxt = pd_on_panel_data_ready ? expansion_power_down : panel_ready_int;

    if (pd_on_mem_addr_bit11)
    begin
      mem_addr_bit11_out_nxt  = expansion_power_down;
      mem_addr_bit11_oe_n_nxt = 1'b0;
    end
    else if (full_addr)
    begin
      mem_addr_bit11_out_nxt  = mem_addr_int11;
      mem_addr_bit11_oe_n_nxt = 1'b0;
    end
    else
    begin
      // General pin two defaults to input so an unused pin never fights
      mem_addr_bit11_out_nxt  = gp2_out_r;
      mem_addr_bit11_oe_n_nxt = !gp2_dir_r;
    end

    wait_nxt      = !host_wait_req;
    wait_oe_n_nxt = wait_tri && !host_access;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pdu_r       <= 8'h00;
      panel_data_ready_r      <= 1'b0;
      mem_addr_bit11_out_r  <= 1'b0;
      mem_addr_bit11_oe_n_r <= 1'b1;
      wait_r      <= 1'b1;
      wait_oe_n_r <= 1'b1;
      exp_act_r   <= 1'b0;
      bclk_r      <= 1'b0;
    end
    else
    begin
      pdu_r       <= pdu_nxt;
      panel_data_ready_r      <= panel_data_ready_nxt;
      mem_addr_bit11_out_r  <= mem_addr_bit11_out_nxt;
      mem_addr_bit11_oe_n_r <= mem_addr_bit11_oe_n_nxt;
      wait_r      <= wait_nxt;
      wait_oe_n_r <= wait_oe_n_nxt;
      exp_act_r   <= exp_en;
      bclk_r      <= bus_clk_div;
    end
  end

  assign panel_data_upper    = pdu_r;
  assign panel_data_ready    = panel_data_ready_r;
  assign mem_addr_bit11_out  = mem_addr_bit11_out_r;
  assign mem_addr_bit11_oe_n = mem_addr_bit11_oe_n_r;
  assign wait_n_out          = wait_r;
  assign wait_n_oe_n         = wait_oe_n_r;
  assign expansion_active    = exp_act_r;
  assign bus_clk_int         = bclk_r;

endmodule : rspc_top

// ### testbench/rspc_far_model.sv
/* Host clock and panel/expansion sources facing rspc_top.
   Assumes clk is the only clock; host clock is derived from it. */
module rspc_far_model
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Sources
  output logic            host_bus_clock_in,
  output logic      [7:0] panel_pixel_upper,
  output logic            panel_ready_int,
  output logic      [7:0] expansion_data,
  output logic            expansion_power_down
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] n_r;
  always_ff @(posedge clk)
  begin
    if (!rst_n) n_r <= 8'h00;
    else n_r <= n_r + 8'h01;
  end
  // Host clock at an eighth of clk; sources change every cycle so stale pins show
  assign host_bus_clock_in    = n_r[2];
  assign panel_pixel_upper    = n_r;
  assign expansion_data       = ~n_r;
  assign panel_ready_int      = n_r[0];
  assign expansion_power_down = ~n_r[0];
endmodule : rspc_far_model

// ### testbench/rspc_monitor.sv
/* Checker for rspc_top, bound to its ports.
   Assumes one clock domain and straps held steady through reset. */
module rspc_monitor
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Straps
  input wire logic        clock_divide_strap,
  input wire logic        expansion_port_strap,
  input wire logic        power_down_pin_strap,
  input wire logic        wait_drive_strap,
  input wire logic [1:0]  mem_config_strap,
  // Pins
  input wire logic        host_access,
  input wire logic        host_wait_req,
  input wire logic        wait_n_out,
  input wire logic        wait_n_oe_n,
  input wire logic [7:0]  panel_pixel_upper,
  input wire logic        panel_ready_int,
  input wire logic [7:0]  panel_data_upper,
  input wire logic        panel_data_ready,
  input wire logic [7:0]  expansion_data,
  input wire logic        expansion_power_down,
  input wire logic        expansion_active
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Own strap copy, taken at the first edge out of reset
  // ****
  logic [1:0] cnt_r;
  logic [5:0] cap_r;
  wire        ready = cnt_r[1];
  wire        pd_dr = cap_r[2] == rspc_pkg::PWR_DN_ENABLED &&
                      cap_r[5:4] == rspc_pkg::MEM_CFG_FULL_ADDR;
  always_ff @(posedge clk)
  begin
    if (!rst_n) cnt_r <= 2'h0;
    else if (cnt_r != 2'h3) cnt_r <= cnt_r + 2'h1;
  end
  always_ff @(posedge clk)
  begin
    if (rst_n && cnt_r == 2'h0) cap_r <= {mem_config_strap, wait_drive_strap,
      power_down_pin_strap, expansion_port_strap, clock_divide_strap};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_rd_hole;
    avs_read && avs_waitrequest && avs_address != rspc_pkg::OFS_STRAP_STATUS &&
    avs_address != rspc_pkg::OFS_PIN_CTRL && avs_address != rspc_pkg::OFS_PIN_STATUS;
  endsequence
  sequence s_rd_strap;
    ready && avs_read && avs_waitrequest && avs_address == rspc_pkg::OFS_STRAP_STATUS;
  endsequence
  chk_bus_answer: assert property (s_req |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  chk_bus_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_hole_zero: assert property (s_rd_hole |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_strap_read: assert property (s_rd_strap |=> avs_readdata[5:0] == cap_r)
    else $error("strap status differs from latched straps");
  chk_upper_route: assert property (ready |-> panel_data_upper ==
    (cap_r[1] == rspc_pkg::EXP_PORT_ON ? $past(expansion_data) : $past(panel_pixel_upper)))
    else $error("upper panel data wrong source");
  chk_exp_flag: assert property (ready |-> expansion_active == cap_r[1])
    else $error("expansion flag differs from strap");
  chk_ready_route: assert property (ready |-> panel_data_ready ==
    (pd_dr ? $past(expansion_power_down) : $past(panel_ready_int)))
    else $error("data-ready pin wrong source");
  chk_wait_drive: assert property (ready |-> wait_n_oe_n ==
    (cap_r[3] == rspc_pkg::WAIT_TRI_IDLE && !$past(host_access)))
    else $error("wait enable wrong");
  chk_wait_level: assert property (ready |-> wait_n_out == !$past(host_wait_req))
    else $error("wait level wrong");
endmodule : rspc_monitor

bind rspc_top rspc_monitor u_mon (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .clock_divide_strap, .expansion_port_strap,
  .power_down_pin_strap, .wait_drive_strap, .mem_config_strap, .host_access,
  .host_wait_req, .wait_n_out, .wait_n_oe_n, .panel_pixel_upper, .panel_ready_int,
  .panel_data_upper, .panel_data_ready, .expansion_data, .expansion_power_down,
  .expansion_active);

// ### testbench/testbench.sv
/* Self-checking bench for rspc_top.
   Assumes rspc_far_model as source side and the bound checker. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wreq, oe_n, bclk, g_out, g_oe_n;
  logic host_access = 1'b0, host_wait_req = 1'b0, g_in = 1'b0, ex_act, pdr_o;
  logic ma = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, rq;
  logic [5:0] cfg = 6'h00;
  logic [7:0] px, ex, px_q, ex_q, pdu;
  logic rdy, pd, rdy_q, pd_q, hbc, wn;
  int n_mismatch = 0, checks = 0;
  always #5 clk = ~clk;
  rspc_far_model far (.clk(clk), .rst_n(rst_n), .host_bus_clock_in(hbc),
    .panel_pixel_upper(px), .panel_ready_int(rdy), .expansion_data(ex),
    .expansion_power_down(pd));
  rspc_top uut (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .clock_divide_strap(cfg[0]), .expansion_port_strap(cfg[1]),
    .power_down_pin_strap(cfg[2]), .wait_drive_strap(cfg[3]), .mem_config_strap(cfg[5:4]),
    .host_bus_clock_in(hbc), .host_access(host_access), .host_wait_req(host_wait_req),
    .bus_clk_int(bclk), .wait_n_out(wn), .wait_n_oe_n(oe_n), .panel_pixel_upper(px),
    .panel_ready_int(rdy), .panel_data_upper(pdu), .panel_data_ready(pdr_o),
    .expansion_data(ex), .expansion_power_down(pd), .expansion_active(ex_act),
    .mem_addr_int11(ma), .mem_addr_bit11_in(g_in), .mem_addr_bit11_out(g_out),
    .mem_addr_bit11_oe_n(g_oe_n));
  always @(posedge clk)
  begin
    px_q <= px;
    ex_q <= ex;
    rdy_q <= rdy;
    pd_q <= pd;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Waits as long as the slave needs; only the watchdog ends a hung access.
  // One idle edge after release keeps back-to-back calls from re-driving
  // the strobes in the same time step.
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    rq = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus
  task do_reset(input logic [5:0] c);
    @(posedge clk);
    cfg <= c;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk({pdu, bclk, pdr_o, g_out, wreq, wn, oe_n, g_oe_n, ex_act}, 32'h1e);
    chk(rdat, 32'h0);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset
  task t_strap(input logic [5:0] c);
    logic pdr, pma, b;
    int tg;
    pdr = !c[2] && c[5:4] == 2'h3;
    pma = !c[2] && c[5:4] != 2'h3;
    do_reset(c);
    bus(1'b0, rspc_pkg::OFS_STRAP_STATUS, 32'h0);
    chk(rq, {25'h0, 1'b1, c});
    bus(1'b0, rspc_pkg::OFS_PIN_STATUS, 32'h0);
    chk(rq & 32'hc, {28'h0, pma, pdr, 2'h0});
    host_wait_req <= 1'b1;
    ma <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(pdu, c[1] ? ex_q : px_q);
    chk({ex_act, pdr_o}, {c[1], pdr ? pd_q : rdy_q});
    if (pma) chk({g_oe_n, g_out}, {1'b0, pd_q});
    else if (c[5:4] == 2'h3) chk({g_oe_n, g_out}, 2'h1);
    else chk(g_oe_n, 1'b1);
    chk({oe_n, wn}, {c[3], 1'b0});
    @(posedge clk);
    host_access <= 1'b1;
    host_wait_req <= 1'b0;
    ma <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({oe_n, wn}, 2'h1);
    @(posedge clk);
    host_access <= 1'b0;
    tg = 0;
    b = bclk;
    repeat (32)
    begin
      @(posedge clk);
      if (bclk !== b) tg++;
      b = bclk;
    end
    chk(32'(tg), c[0] ? 32'h8 : 32'h4);
  endtask : t_strap
  task t_regs(input logic [5:0] c);
    bus(1'b0, rspc_pkg::OFS_PIN_CTRL, 32'h0);
    chk(rq, 32'h0);
    bus(1'b1, rspc_pkg::OFS_PIN_CTRL, 32'h3);
    g_in <= 1'b1;
    bus(1'b0, rspc_pkg::OFS_PIN_STATUS, 32'h0);
    chk(rq & 32'h1, 32'h1);
    chk({g_oe_n, g_out}, 2'h1);
    bus(1'b1, rspc_pkg::OFS_STRAP_STATUS, 32'h7f);
    bus(1'b1, 4'hc, 32'h0);
    bus(1'b0, rspc_pkg::OFS_STRAP_STATUS, 32'h0);
    chk(rq, {25'h0, 1'b1, c});
    bus(1'b0, 4'hc, 32'h0);
    chk(rq, 32'h0);
    bus(1'b0, rspc_pkg::OFS_PIN_CTRL, 32'h0);
    chk(rq, 32'h3);
  endtask : t_regs
  task final_report;
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    final_report;
  end
  initial
  begin
    t_strap(6'h00);
    t_strap(6'h33);
    t_strap(6'h1d);
    t_regs(6'h1d);
    t_strap(6'h3e);
    final_report;
  end
endmodule : testbench
